// ===== tcpu_pkg.sv
// package: register map, field layout and bus carriers of the timer unit
// Behaviour
// - interval mode clears on match0, raises match0 request
// - interval overflow only when compare 0 is FFFFH
// - count clock chosen by prescaler bits 1:0
// - pulse mode drives wave from compare 0/1
// - period compare0+1, active width compare1+1
// - capture needs two equal samples at the count clock (fx in input-edge mode)
// - input 0 edge captures into register 1
// - input 1 edge captures into register 0
// - opposite input 0 edge captures into register 0
// - restart: capture register 1, then clear counter
// - match inversion toggles output; disabled pin low
// - edge code 00 fall, 01 rise, 11 both
// - clock code fx, fx/4, fx/256, input edge
// - control bits pick compare/capture and trigger
package tcpu_pkg;

  // byte offsets of the registers on the bus
  localparam logic [7:0] OFS_MODE    = 8'h00;
  localparam logic [7:0] OFS_CCCTRL  = 8'h04;
  localparam logic [7:0] OFS_OUTCTRL = 8'h08;
  localparam logic [7:0] OFS_PRESC   = 8'h0C;
  localparam logic [7:0] OFS_REG0    = 8'h10;
  localparam logic [7:0] OFS_REG1    = 8'h14;
  localparam logic [7:0] OFS_COUNT   = 8'h18;
  localparam logic [7:0] OFS_STATUS  = 8'h1C;

  // timer_mode_ctrl fields
  localparam int MODE_OVF_BIT     = 0;
  localparam int MODE_OP_LSB      = 2;
  localparam int MODE_RESTART_BIT = 4;
  localparam logic [7:0] MODE_RW_MASK = 8'h1C;

  // capcmp_ctrl fields
  localparam int REG0_CAP_BIT  = 0;
  localparam int REG0_TRIG_BIT = 1;
  localparam int REG1_CAP_BIT  = 2;
  localparam logic [7:0] CC_RW_MASK = 8'h07;

  // output_ctrl fields; set and reset bits are write-only
  localparam int OUT_EN_BIT   = 0;
  localparam int INV0_BIT     = 1;
  localparam int FF_RESET_BIT = 2;
  localparam int FF_SET_BIT   = 3;
  localparam int INV1_BIT     = 4;
  localparam logic [7:0] OUT_RW_MASK = 8'h13;

  // prescaler_mode fields
  localparam int CLK_SEL_LSB  = 0;
  localparam int IN0_EDGE_LSB = 4;
  localparam int IN1_EDGE_LSB = 6;
  localparam logic [7:0] PRESC_RW_MASK = 8'hF3;

  // status fields (read only)
  localparam int STAT_RUN_BIT  = 0;
  localparam int STAT_OUT_BIT  = 1;
  localparam int STAT_LVL0_BIT = 2;
  localparam int STAT_LVL1_BIT = 3;

  // reset values and the counter maximum
  localparam logic [7:0]  RST_CTRL = 8'h00;
  localparam logic [15:0] RST_CNT  = 16'h0000;
  localparam logic [7:0]  RST_DIV  = 8'h00;
  localparam logic [15:0] CNT_MAX  = 16'hFFFF;

  // counter operating mode codes
  localparam logic [1:0] OP_STOP  = 2'h0;
  localparam logic [1:0] OP_FREE  = 2'h1;
  localparam logic [1:0] OP_BAD   = 2'h2;
  localparam logic [1:0] OP_MATCH = 2'h3;

  // edge select codes
  localparam logic [1:0] EDGE_FALL = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_BAD  = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;

  // count clock select codes and divider terminal masks
  localparam logic [1:0] CLK_FX     = 2'h0;
  localparam logic [1:0] CLK_DIV4   = 2'h1;
  localparam logic [1:0] CLK_DIV256 = 2'h2;
  localparam logic [1:0] CLK_EDGE   = 2'h3;
  localparam logic [7:0] DIV4_MASK   = 8'h03;
  localparam logic [7:0] DIV256_MASK = 8'hFF;

  // classic wishbone request from the master
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } tcpu_wb_req_t;

  // classic wishbone answer to the master
  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } tcpu_wb_rsp_t;

endpackage : tcpu_pkg

// ===== tcpu_sampler.sv
// module: pin synchroniser and two-sample noise filter for one capture input
`timescale 1ns/1ps
`default_nettype none
module tcpu_sampler (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic pin_i,
  input  wire logic sample_i,
  output logic      level_o,
  output logic      rise_o,
  output logic      fall_o
);

  logic [2:0] sync;
  logic       agreed;
  logic       smp;

  // three stages; only the second and third are ever looked at
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync <= 3'h0;
    end else begin
      sync <= {sync[1:0], pin_i};
    end
  end

  // a pin change counts only once the last two stages agree
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      agreed <= 1'b0;
    end else if (sync[1] == sync[2]) begin
      agreed <= sync[2];
    end
  end

  // accept a new level after two equal sample ticks (fx in input-edge mode); level starts
  // at 0, so a pin high out of reset shows one rising edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      smp     <= 1'b0;
      level_o <= 1'b0;
      rise_o  <= 1'b0;
      fall_o  <= 1'b0;
    end else begin
      rise_o <= 1'b0;
      fall_o <= 1'b0;
      if (sample_i) begin
        smp <= agreed;
        if (agreed == smp && agreed != level_o) begin
          level_o <= agreed;
          rise_o  <= agreed;
          fall_o  <= ~agreed;
        end
      end
    end
  end

endmodule : tcpu_sampler
`default_nettype wire

// ===== tcpu_timer.sv
// module: 16-bit interval / pulse generator / capture timer, wishbone slave
//
// The address map and register access over Wishbone were decided locally.
`timescale 1ns/1ps
`default_nettype none
module tcpu_timer (
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  input  wire tcpu_pkg::tcpu_wb_req_t wb_i,
  output tcpu_pkg::tcpu_wb_rsp_t      wb_o,
  input  wire logic                   capture_in_0_i,
  input  wire logic                   capture_in_1_i,
  output logic                        timer_out_pin_o,
  output logic                        match0_irq_o,
  output logic                        match1_irq_o
);
  import tcpu_pkg::*;

  // software-visible state
  logic [7:0]  timer_mode_ctrl;
  logic [7:0]  capcmp_ctrl;
  logic [7:0]  output_ctrl;
  logic [7:0]  prescaler_mode;
  logic [15:0] capcmp_reg_0;
  logic [15:0] capcmp_reg_1;
  logic [15:0] main_counter;
  logic        overflow_flag;
  logic        out_ff;

  // bus handshake state
  logic        ack;
  logic [31:0] rd_dat;
  logic [31:0] next_rd_dat;

  // internal timing
  logic [7:0]  div;
  logic        base_tick;
  logic        count_tick;

  // decoded control
  logic [1:0]  op;
  logic        running;
  logic        restart_mode;
  logic [1:0]  clk_sel;
  logic [1:0]  in0_edge;
  logic [1:0]  in1_edge;
  logic        cmp0_mode;
  logic        cmp1_mode;

  // filtered inputs
  logic        lvl0;
  logic        lvl1;
  logic        rise0;
  logic        fall0;
  logic        rise1;
  logic        fall1;
  logic        in0_valid;
  logic        in1_valid;
  logic        in0_reverse;

  // events
  logic        match0;
  logic        match1;
  logic        clear_match;
  logic        restart;
  logic        ovf_set;
  logic        cap0_in1;
  logic        cap0_rev;
  logic        cap1;
  logic        toggle;

  // write strobes
  logic        wr_hit;
  logic        wr_b0;
  logic        wr_b1;

  // edge-code decode shared by both inputs
  function automatic logic edge_hit(input logic [1:0] es,
                                    input logic r,
                                    input logic f);
    logic hit;
    hit = 1'b0;
    case (es)
      EDGE_FALL: hit = f;
      EDGE_RISE: hit = r;
      EDGE_BOTH: hit = r | f;
      default:   hit = 1'b0;
    endcase
    return hit;
  endfunction : edge_hit

  // field decode
  assign op           = timer_mode_ctrl[MODE_OP_LSB +: 2];
  assign running      = (op == OP_FREE) || (op == OP_MATCH); // code 10 stops
  assign restart_mode = (op == OP_FREE) && timer_mode_ctrl[MODE_RESTART_BIT];
  assign clk_sel      = prescaler_mode[CLK_SEL_LSB +: 2];
  assign in0_edge     = prescaler_mode[IN0_EDGE_LSB +: 2];
  assign in1_edge     = prescaler_mode[IN1_EDGE_LSB +: 2];
  assign cmp0_mode    = ~capcmp_ctrl[REG0_CAP_BIT];
  assign cmp1_mode    = ~capcmp_ctrl[REG1_CAP_BIT];

  // the write lands at the edge where the master sees ack high
  assign wr_hit = wb_i.cyc & wb_i.stb & wb_i.we & ack;
  assign wr_b0  = wr_hit & wb_i.sel[0];
  assign wr_b1  = wr_hit & wb_i.sel[1];

  // free-running prescaler, never stopped so fx/256 phase is arbitrary
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div <= RST_DIV;
    end else begin
      div <= div + 8'h01;
    end
  end

  // sample tick for filters; input-edge counting samples at fx
  always_comb begin
    base_tick = 1'b1;
    case (clk_sel)
      CLK_FX:     base_tick = 1'b1;
      CLK_DIV4:   base_tick = (div & DIV4_MASK) == DIV4_MASK;
      CLK_DIV256: base_tick = (div & DIV256_MASK) == DIV256_MASK;
      CLK_EDGE:   base_tick = 1'b1;
      default:    base_tick = 1'b1;
    endcase
  end

  // capture input 0 filter
  tcpu_sampler u_in0 (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .pin_i    (capture_in_0_i),
    .sample_i (base_tick),
    .level_o  (lvl0),
    .rise_o   (rise0),
    .fall_o   (fall0)
  );

  // capture input 1 filter
  tcpu_sampler u_in1 (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .pin_i    (capture_in_1_i),
    .sample_i (base_tick),
    .level_o  (lvl1),
    .rise_o   (rise1),
    .fall_o   (fall1)
  );

  // valid and reverse-phase edges
  assign in0_valid   = edge_hit(in0_edge, rise0, fall0);
  assign in1_valid   = edge_hit(in1_edge, rise1, fall1);
  // no reverse phase exists when both edges are selected
  assign in0_reverse = ((in0_edge == EDGE_RISE) & fall0) |
                       ((in0_edge == EDGE_FALL) & rise0);

  // count enable: prescaled clock or valid edges on input 0
  assign count_tick = running &
                      ((clk_sel == CLK_EDGE) ? in0_valid : base_tick);

  // compare events happen on the count tick that leaves the matching value
  assign match0 = count_tick & cmp0_mode & (main_counter == capcmp_reg_0);
  assign match1 = count_tick & cmp1_mode & (main_counter == capcmp_reg_1);
  assign clear_match = (op == OP_MATCH) & match0;
  assign restart     = restart_mode & in0_valid;

  // in match mode a rollover only happens when compare 0 is FFFFH
  assign ovf_set = count_tick & (main_counter == CNT_MAX) &
                   ((op != OP_MATCH) | (capcmp_reg_0 == CNT_MAX));

  // capture triggers
  assign cap1     = running & ~cmp1_mode & in0_valid;
  assign cap0_in1 = running & ~cmp0_mode &
                    ~capcmp_ctrl[REG0_TRIG_BIT] & in1_valid;
  assign cap0_rev = running & ~cmp0_mode &
                    capcmp_ctrl[REG0_TRIG_BIT] & in0_reverse;

  // main counter; stopping clears it, restart beats a tick
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      main_counter <= RST_CNT;
    end else if (!running) begin
      main_counter <= RST_CNT;
    end else if (restart) begin
      main_counter <= RST_CNT;
    end else if (clear_match) begin
      main_counter <= RST_CNT;
    end else if (count_tick) begin
      main_counter <= main_counter + 16'h0001; // wraps to 0000H
    end
  end

  // sticky overflow; a set in the clearing cycle wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      overflow_flag <= 1'b0;
    end else if (ovf_set) begin
      overflow_flag <= 1'b1;
    end else if (wr_b0 && wb_i.adr == OFS_MODE &&
                 !wb_i.dat[MODE_OVF_BIT]) begin
      overflow_flag <= 1'b0;
    end
  end

  // mode control; the overflow bit lives in its own flop above
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      timer_mode_ctrl <= RST_CTRL;
    end else if (wr_b0 && wb_i.adr == OFS_MODE) begin
      timer_mode_ctrl <= wb_i.dat[7:0] & MODE_RW_MASK;
    end
  end

  // capture/compare control; only implemented bits are kept
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      capcmp_ctrl <= RST_CTRL;
    end else if (wr_b0 && wb_i.adr == OFS_CCCTRL) begin
      capcmp_ctrl <= wb_i.dat[7:0] & CC_RW_MASK;
    end
  end

  // output control; set and reset strobes are not stored, so read 0
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      output_ctrl <= RST_CTRL;
    end else if (wr_b0 && wb_i.adr == OFS_OUTCTRL) begin
      output_ctrl <= wb_i.dat[7:0] & OUT_RW_MASK;
    end
  end

  // prescaler mode: count clock and both edge selects
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prescaler_mode <= RST_CTRL;
    end else if (wr_b0 && wb_i.adr == OFS_PRESC) begin
      prescaler_mode <= wb_i.dat[7:0] & PRESC_RW_MASK;
    end
  end

  // register 0: capture beats a software write in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      capcmp_reg_0 <= RST_CNT;
    end else if (cap0_in1 || cap0_rev) begin
      capcmp_reg_0 <= main_counter;
    end else if (wb_i.adr == OFS_REG0) begin
      if (wr_b0) begin
        capcmp_reg_0[7:0] <= wb_i.dat[7:0];
      end
      if (wr_b1) begin
        capcmp_reg_0[15:8] <= wb_i.dat[15:8];
      end
    end
  end

  // register 1: value taken before any restart clears the counter
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      capcmp_reg_1 <= RST_CNT;
    end else if (cap1) begin
      capcmp_reg_1 <= main_counter;
    end else if (wb_i.adr == OFS_REG1) begin
      if (wr_b0) begin
        capcmp_reg_1[7:0] <= wb_i.dat[7:0];
      end
      if (wr_b1) begin
        capcmp_reg_1[15:8] <= wb_i.dat[15:8];
      end
    end
  end

  // output flip-flop; two inverting matches in one cycle cancel out
  assign toggle = (match0 & output_ctrl[INV0_BIT]) ^
                  (match1 & output_ctrl[INV1_BIT]);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      out_ff <= 1'b0;
    end else if (!output_ctrl[OUT_EN_BIT]) begin
      out_ff <= 1'b0;
    end else if (wr_b0 && wb_i.adr == OFS_OUTCTRL &&
                 (wb_i.dat[FF_SET_BIT] ^ wb_i.dat[FF_RESET_BIT])) begin
      out_ff <= wb_i.dat[FF_SET_BIT];
    end else if (toggle) begin
      out_ff <= ~out_ff;
    end
  end

  assign timer_out_pin_o = out_ff;

  // one-cycle compare-0 request; reverse-phase capture raises none
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      match0_irq_o <= 1'b0;
    end else begin
      match0_irq_o <= match0 | cap0_in1;
    end
  end

  // one-cycle compare-1 request, from a match or a capture
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      match1_irq_o <= 1'b0;
    end else begin
      match1_irq_o <= match1 | cap1;
    end
  end

  // read mux; unmapped offsets read zero
  always_comb begin
    next_rd_dat = 32'h0000_0000;
    case (wb_i.adr)
      OFS_MODE: begin
        next_rd_dat[7:0] = timer_mode_ctrl;
        next_rd_dat[MODE_OVF_BIT] = overflow_flag;
      end
      OFS_CCCTRL:  next_rd_dat[7:0]  = capcmp_ctrl;
      OFS_OUTCTRL: next_rd_dat[7:0]  = output_ctrl;
      OFS_PRESC:   next_rd_dat[7:0]  = prescaler_mode;
      OFS_REG0:    next_rd_dat[15:0] = capcmp_reg_0;
      OFS_REG1:    next_rd_dat[15:0] = capcmp_reg_1;
      OFS_COUNT:   next_rd_dat[15:0] = main_counter;
      OFS_STATUS: begin
        next_rd_dat[STAT_RUN_BIT]  = running;
        next_rd_dat[STAT_OUT_BIT]  = out_ff;
        next_rd_dat[STAT_LVL0_BIT] = lvl0;
        next_rd_dat[STAT_LVL1_BIT] = lvl1;
      end
      default: next_rd_dat = 32'h0000_0000;
    endcase
  end

  // ack one cycle after the request, dropped the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack    <= 1'b0;
      rd_dat <= 32'h0000_0000;
    end else begin
      ack <= wb_i.cyc & wb_i.stb & ~ack;
      if (wb_i.cyc && wb_i.stb && !ack) begin
        rd_dat <= next_rd_dat;
      end
    end
  end

  assign wb_o.ack = ack;
  assign wb_o.dat = rd_dat;

endmodule : tcpu_timer
`default_nettype wire

// ===== tcpu_timer_checker.sv
// checker: port-level timing checks of the timer unit
`timescale 1ns/1ps
`default_nettype none
module tcpu_timer_checker (
  input wire logic                   clk_i,
  input wire logic                   rst_i,
  input wire tcpu_pkg::tcpu_wb_req_t wb_i,
  input wire tcpu_pkg::tcpu_wb_rsp_t wb_o,
  input wire logic                   capture_in_0_i,
  input wire logic                   capture_in_1_i,
  input wire logic                   timer_out_pin_o,
  input wire logic                   match0_irq_o,
  input wire logic                   match1_irq_o
);
  import tcpu_pkg::*;
  logic oe;
  logic run;
  logic wr;
  // a write lands at the edge where ack is high
  assign wr = wb_o.ack && wb_i.we && wb_i.sel[0];
  // shadow of the output enable, so a disabled pin can be judged
  always_ff @(posedge clk_i) begin
    if (rst_i) oe <= 1'b0;
    else if (wr && wb_i.adr == OFS_OUTCTRL) oe <= wb_i.dat[OUT_EN_BIT];
  end
  // shadow of the run state: op codes 01 and 11 both have the low bit set
  always_ff @(posedge clk_i) begin
    if (rst_i) run <= 1'b0;
    else if (wr && wb_i.adr == OFS_MODE) run <= wb_i.dat[MODE_OP_LSB];
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  req_ack_a: assert property (wb_i.cyc && wb_i.stb && !wb_o.ack |=> wb_o.ack)
    else $error("ack missing one cycle after request");
  ack_single_a: assert property (wb_o.ack |=> !wb_o.ack)
    else $error("ack held longer than one cycle");
  ack_cause_a: assert property (wb_o.ack |-> $past(wb_i.cyc && wb_i.stb))
    else $error("ack without request");
  unmapped_zero_a: assert property (wb_o.ack && !wb_i.we &&
    wb_i.adr > OFS_STATUS |-> wb_o.dat == 32'h0)
    else $error("unmapped read not zero");
  status_pin_a: assert property (wb_o.ack && !wb_i.we && wb_i.adr ==
    OFS_STATUS |-> wb_o.dat[STAT_OUT_BIT] == $past(timer_out_pin_o))
    else $error("status output bit differs from pin");
  irq1_pulse_a: assert property (match1_irq_o |=> !match1_irq_o)
    else $error("match1 request longer than a cycle");
  pin_off_a: assert property (!oe && !$past(oe) |-> !timer_out_pin_o)
    else $error("pin high while output disabled");
  irq_run_a: assert property ((match0_irq_o || match1_irq_o) |->
    (run || $past(run) || $past(run, 2) || $past(run, 3)))
    else $error("request raised while stopped");
endmodule : tcpu_timer_checker
bind tcpu_timer tcpu_timer_checker u_chk (.clk_i, .rst_i, .wb_i, .wb_o,
  .capture_in_0_i, .capture_in_1_i, .timer_out_pin_o, .match0_irq_o,
  .match1_irq_o);
`default_nettype wire

// ===== tcpu_pulse_src.sv
// partner: pulse sources on the capture pins and a load timing the output
`timescale 1ns/1ps
`default_nettype none
module tcpu_pulse_src (
  input  wire logic  clk_i,
  input  wire logic  rst_i,
  input  wire logic  lvl0_i,
  input  wire logic  lvl1_i,
  input  wire logic  pin_i,
  output logic       in0_o,
  output logic       in1_o,
  output logic [15:0] hi_len_o,
  output logic [15:0] per_len_o
);
  logic [15:0] hi_cnt;
  logic [15:0] per_cnt;
  logic        pin_q;
  // sources are registered so pins move just after an edge
  always_ff @(posedge clk_i) begin
    in0_o <= lvl0_i;
    in1_o <= lvl1_i;
  end
  // load: high time and rise-to-rise period, in clock cycles
  always_ff @(posedge clk_i) begin
    pin_q <= pin_i;
    if (rst_i) begin
      per_cnt <= 16'h0;
      hi_cnt  <= 16'h0;
    end else if (pin_i && !pin_q) begin
      per_len_o <= per_cnt;
      per_cnt   <= 16'h1;
      hi_cnt    <= 16'h1;
    end else begin
      per_cnt <= per_cnt + 16'h1;
      if (pin_i) hi_cnt <= hi_cnt + 16'h1;
      if (!pin_i && pin_q) hi_len_o <= hi_cnt;
    end
  end
endmodule : tcpu_pulse_src
`default_nettype wire

// ===== tcpu_timer_test.sv
// testbench: register, interval, pulse and capture scenarios of the timer
`timescale 1ns/1ps
`default_nettype none
module tcpu_timer_test;
  import tcpu_pkg::*;
  logic         clk_i, rst_i, lvl0, lvl1, in0, in1, pin, irq0, irq1;
  tcpu_wb_req_t req;
  tcpu_wb_rsp_t rsp;
  logic [15:0]  hi_len, per_len;
  logic [31:0]  rdv, a;
  int           err_total, checks_done, cyc_n, n0, n1, t0, nv, mv, s0, s1;
  int           dv[3] = '{1, 4, 256};
  int           ex[4] = '{1, 1, 0, 2};

  tcpu_timer DUT (.clk_i, .rst_i, .wb_i(req), .wb_o(rsp),
    .capture_in_0_i(in0), .capture_in_1_i(in1), .timer_out_pin_o(pin),
    .match0_irq_o(irq0), .match1_irq_o(irq1));
  tcpu_pulse_src u_src (.clk_i, .rst_i, .lvl0_i(lvl0), .lvl1_i(lvl1),
    .pin_i(pin), .in0_o(in0), .in1_o(in1), .hi_len_o(hi_len),
    .per_len_o(per_len));

  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  // request counts and the cycle of the last compare-0 request
  always @(posedge clk_i) begin
    cyc_n <= cyc_n + 1;
    if (irq0 === 1'b1) begin
      n0 <= n0 + 1;
      t0 <= cyc_n;
    end
    if (irq1 === 1'b1) n1 <= n1 + 1;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                     input string nm);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // one classic cycle; held until ack is seen, data taken at that edge;
  // only the watchdog ends a wait that never gets its answer
  task automatic wb(input logic we, input logic [7:0] ad,
                    input logic [31:0] d);
    @(posedge clk_i);
    req <= '{1'b1, 1'b1, we, ad, 4'h3, d};
    do begin
      @(posedge clk_i);
    end while (rsp.ack !== 1'b1);
    chk(rsp.ack, 1'b1, "wb_ack");
    rdv = rsp.dat;
    req <= '0;
  endtask : wb
  // stop first: compare 0 and mode bits change only while stopped
  task automatic setup(input logic [31:0] cc, oc, pr, r0, r1, md);
    wb(1'b1, OFS_MODE, 32'h0);
    wb(1'b1, OFS_CCCTRL, cc);
    wb(1'b1, OFS_OUTCTRL, oc);
    wb(1'b1, OFS_PRESC, pr);
    wb(1'b1, OFS_REG0, r0);
    wb(1'b1, OFS_REG1, r1);
    wb(1'b1, OFS_MODE, md);
  endtask : setup
  task automatic wait0();
    int s;
    s = n0;
    for (int k = 0; k < 3000 && n0 == s; k++) @(posedge clk_i);
    chk(n0 != s, 1, "match0_irq");
  endtask : wait0
  task automatic pulse0(input int hi, lo);
    lvl0 <= 1'b1;
    repeat (hi) @(posedge clk_i);
    lvl0 <= 1'b0;
    repeat (lo) @(posedge clk_i);
  endtask : pulse0
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : print_verdict

  // watchdog: the longest scenario is the counter wrap, about 66k cycles
  initial begin
    repeat (90000) @(posedge clk_i);
    chk(0, 1, "watchdog");
    print_verdict();
  end

  initial begin
    req = '0;
    lvl0 = 1'b0;
    lvl1 = 1'b0;
    rst_i = 1'b1;
    void'($urandom(32'h51FF293B));
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    // reset contents, an unmapped place, write-only output bits
    for (int i = 0; i < 8; i++) begin
      wb(1'b0, 8'(i * 4), 32'h0);
      chk(rdv, 32'h0, "reset_value");
    end
    wb(1'b1, 8'h20, $urandom);
    wb(1'b0, 8'h20, 32'h0);
    chk(rdv, 32'h0, "unmapped");
    wb(1'b1, OFS_OUTCTRL, 32'h1F);
    wb(1'b0, OFS_OUTCTRL, 32'h0);
    chk(rdv, 32'(OUT_RW_MASK), "out_ctrl");
    // interval on each internal clock choice
    for (int c = 0; c < 3; c++) begin
      nv = (c == 2) ? 1 : 1 + $urandom % 7;
      setup(0, 0, c, nv, 0, 32'h0C);
      wait0();
      a = t0;
      wait0();
      chk(t0 - a, (nv + 1) * dv[c], "interval");
    end
    wb(1'b0, OFS_MODE, 32'h0);
    chk(rdv[MODE_OVF_BIT], 1'b0, "ovf_interval");
    // counting on input 0 edges
    nv = 2 + $urandom % 4;
    setup(0, 0, 32'h13, 0, 0, 32'h04);
    repeat (nv) pulse0(4, 6);
    wb(1'b0, OFS_COUNT, 32'h0);
    chk(rdv, nv, "edge_count");
    // free-run wrap sets a sticky flag that only software clears
    setup(0, 0, 0, 0, 0, 32'h04);
    repeat (65540) @(posedge clk_i);
    wb(1'b0, OFS_MODE, 32'h0);
    chk(rdv[MODE_OVF_BIT], 1'b1, "ovf_set");
    wb(1'b1, OFS_MODE, 32'h04);
    wb(1'b0, OFS_MODE, 32'h0);
    chk(rdv[MODE_OVF_BIT], 1'b0, "ovf_clear");
    // pulse generation with the narrowest and widest width
    nv = 3 + $urandom % 7;
    for (int i = 0; i < 2; i++) begin
      mv = i ? nv - 1 : 0;
      setup(0, 32'h17, 0, nv, mv, 32'h0C);
      repeat (3 * nv + 9) @(posedge clk_i);
      chk(hi_len == mv + 1 || hi_len == nv - mv, 1, "ppg_width");
      chk(per_len, nv + 1, "ppg_period");
    end
    // running width change: match-1 inversion off, new width, one tick
    mv = $urandom % nv;
    wb(1'b1, OFS_OUTCTRL, 32'h03);
    wb(1'b1, OFS_REG1, mv);
    @(posedge clk_i);
    wb(1'b1, OFS_OUTCTRL, 32'h13);
    repeat (3 * nv + 9) @(posedge clk_i);
    chk(hi_len == mv + 1 || hi_len == nv - mv, 1, "ppg_rewidth");
    chk(per_len, nv + 1, "ppg_period");
    wb(1'b0, OFS_STATUS, 32'h0);
    chk(rdv[STAT_RUN_BIT], 1'b1, "status_run");
    // software set and reset of the output flop, then disable from high
    wb(1'b1, OFS_OUTCTRL, 32'h01);
    wb(1'b1, OFS_OUTCTRL, 32'h09);
    repeat (2) @(posedge clk_i);
    chk(pin, 1'b1, "ff_set");
    wb(1'b1, OFS_OUTCTRL, 32'h05);
    repeat (2) @(posedge clk_i);
    chk(pin, 1'b0, "ff_reset");
    wb(1'b1, OFS_OUTCTRL, 32'h09);
    wb(1'b1, OFS_OUTCTRL, 32'h0);
    repeat (3) @(posedge clk_i);
    chk(pin, 1'b0, "pin_off");
    // every edge code on input 0, then a pulse too short to pass
    for (int e = 0; e < 5; e++) begin
      setup(32'h04, 0, (e == 4 ? 3 : e) << 4, 0, 0, 32'h04);
      s1 = n1;
      pulse0(e == 4 ? 1 : 8, 12);
      chk(n1 - s1, e == 4 ? 0 : ex[e], "edge_code");
    end
    // both inputs rise, input 1 later by a known gap
    nv = 3 + $urandom % 20;
    setup(32'h05, 0, 32'h50, 0, 0, 32'h04);
    s0 = n0;
    s1 = n1;
    lvl0 <= 1'b1;
    repeat (nv) @(posedge clk_i);
    lvl1 <= 1'b1;
    repeat (12) @(posedge clk_i);
    lvl0 <= 1'b0;
    lvl1 <= 1'b0;
    repeat (12) @(posedge clk_i);
    chk(n0 - s0, 1, "in1_irq");
    chk(n1 - s1, 1, "in0_irq");
    wb(1'b0, OFS_REG1, 32'h0);
    a = rdv;
    wb(1'b0, OFS_REG0, 32'h0);
    chk(rdv - a, nv, "capture_gap");
    // opposite edge of input 0 into register 0, no request from it
    setup(32'h07, 0, 32'h10, 0, 0, 32'h04);
    s0 = n0;
    pulse0(nv, 12);
    chk(n0 - s0, 0, "rev_irq");
    wb(1'b0, OFS_REG1, 32'h0);
    a = rdv;
    wb(1'b0, OFS_REG0, 32'h0);
    chk(rdv - a, nv, "rev_capture");
    // restart on single rising edges a known period apart
    nv = 10 + $urandom % 20;
    setup(32'h04, 0, 32'h10, 0, 0, 32'h14);
    repeat (2) pulse0(3, nv - 3);
    wb(1'b0, OFS_REG1, 32'h0);
    chk(rdv, nv - 1, "restart");
    print_verdict();
  end
endmodule : tcpu_timer_test
`default_nettype wire
